// >>> include/pct_pkg.sv
// Purpose: shared constants and types for the panel/crt timing block
// Assumes: byte-wide registers, one aligned bus word each
// Notes: byte address of a register is four times its index
`default_nettype none
package pct_pkg;
  // ****************************************
  // register indices
  // ****************************************
  localparam int PCT_NREG = 14;
  localparam logic [3:0] PCT_IDX_ID = 4'h0;
  localparam logic [3:0] PCT_IDX_PANEL = 4'h2;
  localparam logic [3:0] PCT_IDX_TGL = 4'h3;
  localparam logic [3:0] PCT_IDX_HDW = 4'h4;
  localparam logic [3:0] PCT_IDX_HND = 4'h5;
  localparam logic [3:0] PCT_IDX_HSS = 4'h6;
  localparam logic [3:0] PCT_IDX_HSW = 4'h7;
  localparam logic [3:0] PCT_IDX_VDL = 4'h8;
  localparam logic [3:0] PCT_IDX_VDH = 4'h9;
  localparam logic [3:0] PCT_IDX_VND = 4'ha;
  localparam logic [3:0] PCT_IDX_VSS = 4'hb;
  localparam logic [3:0] PCT_IDX_VSW = 4'hc;
  localparam logic [3:0] PCT_IDX_MODE = 4'hd;
  // ****************************************
  // field positions and values
  // ****************************************
  localparam int PCT_PT_TFT = 0;
  localparam int PCT_PT_DUAL = 1;
  localparam int PCT_PT_COLOR = 2;
  localparam int PCT_PT_FMT2 = 3;
  localparam int PCT_POL_CRT = 7;
  localparam int PCT_POL_PNL = 6;
  localparam int PCT_VND_STAT = 7;
  localparam logic [7:0] PCT_RST_VAL = 8'h00;
  localparam logic [1:0] PCT_REV_CODE = 2'h0; // revision value is arbitrary
  localparam logic [10:0] PCT_UNIT = 11'h008;
  localparam logic [10:0] PCT_ONE = 11'h001;
  localparam logic [10:0] PCT_PLINE_W = 11'h008;
  localparam logic [5:0] PCT_TGL_ONE = 6'h01;

  typedef enum logic [1:0] {
    PCT_NORMAL, PCT_LINE_DBL, PCT_INTERLACE, PCT_EVEN_ONLY
  } pct_vres_e;

  typedef enum {PCT_BUS_IDLE, PCT_BUS_RDWAIT} pct_bus_e;

  typedef struct packed {
    logic line;
    logic frame;
    logic hsync;
    logic vsync;
    logic toggle;
  } pct_sync_s;

  function automatic logic [7:0] pct_wmask(input logic [3:0] idx);
    case (idx)
      PCT_IDX_PANEL: pct_wmask = 8'h0f;
      PCT_IDX_TGL: pct_wmask = 8'h3f;
      PCT_IDX_HDW: pct_wmask = 8'h7f;
      PCT_IDX_HND, PCT_IDX_HSS: pct_wmask = 8'h1f;
      PCT_IDX_HSW: pct_wmask = 8'hcf;
      PCT_IDX_VDL: pct_wmask = 8'hff;
      PCT_IDX_VDH: pct_wmask = 8'h03;
      PCT_IDX_VND, PCT_IDX_VSS: pct_wmask = 8'h3f;
      PCT_IDX_VSW: pct_wmask = 8'hc7;
      PCT_IDX_MODE: pct_wmask = 8'h60;
      default: pct_wmask = 8'h00;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> src/pct_timing_top.sv
// Purpose: panel/crt timing configuration and sync generation
// Assumes: ahb-lite slave, single word transfers, one clock
// Notes: timing counts run on a pixel enable from a divider
//
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
module pct_timing_top
  import pct_pkg::*;
#(
  parameter int PIX_DIV = 1,
  parameter int HAW = 32,
  parameter logic [5:0] PRODUCT_ID = 6'h2a // value is arbitrary
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [HAW-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  output pct_sync_s sync_o,
  output logic disp_en_o,
  output logic panel_tft_o,
  output logic panel_color_o,
  output logic panel_dual_o,
  output logic panel_fmt2_o,
  output logic [1:0] vres_mode_o,
  output logic field_odd_o,
  output logic lcd_scan_en_o
);

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] regs_reg [PCT_NREG];
  logic wr_pend_reg;
  logic [3:0] wr_idx_reg;

  for (genvar i = 0; i < PCT_NREG; i++) begin : g_reg
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        regs_reg[i] <= PCT_RST_VAL;
      end else if (wr_pend_reg && wr_idx_reg == 4'(i)) begin
        regs_reg[i] <= hwdata_i[7:0] & pct_wmask(4'(i));
      end
    end
  end

  wire logic tft = regs_reg[PCT_IDX_PANEL][PCT_PT_TFT];
  wire logic [5:0] tgl_rate = regs_reg[PCT_IDX_TGL][5:0];
  wire logic [6:0] hdw = regs_reg[PCT_IDX_HDW][6:0];
  wire logic [4:0] hnd = regs_reg[PCT_IDX_HND][4:0];
  wire logic [4:0] hss = regs_reg[PCT_IDX_HSS][4:0];
  wire logic [3:0] hsw = regs_reg[PCT_IDX_HSW][3:0];
  wire logic hpol_crt = regs_reg[PCT_IDX_HSW][PCT_POL_CRT];
  wire logic hpol_pnl = regs_reg[PCT_IDX_HSW][PCT_POL_PNL];
  wire logic [9:0] vdh = {regs_reg[PCT_IDX_VDH][1:0], regs_reg[PCT_IDX_VDL]};
  wire logic [5:0] vnd = regs_reg[PCT_IDX_VND][5:0];
  wire logic [5:0] vss = regs_reg[PCT_IDX_VSS][5:0];
  wire logic [2:0] vsw = regs_reg[PCT_IDX_VSW][2:0];
  wire logic vpol_crt = regs_reg[PCT_IDX_VSW][PCT_POL_CRT];
  wire logic vpol_pnl = regs_reg[PCT_IDX_VSW][PCT_POL_PNL];
  wire logic [1:0] vres = regs_reg[PCT_IDX_MODE][6:5];

  // panel mode bits go straight out; the datapath decodes them
  assign panel_tft_o = tft;
  assign panel_color_o = regs_reg[PCT_IDX_PANEL][PCT_PT_COLOR];
  assign panel_dual_o = regs_reg[PCT_IDX_PANEL][PCT_PT_DUAL];
  assign panel_fmt2_o = regs_reg[PCT_IDX_PANEL][PCT_PT_FMT2];
  assign vres_mode_o = vres;

  // ****************************************
  // derived periods
  // ****************************************
  wire logic [10:0] h_disp = {1'b0, hdw, 3'b000} + PCT_UNIT;
  wire logic [10:0] h_tot = h_disp + {3'b000, hnd, 3'b000} + PCT_UNIT;
  wire logic [10:0] hs_beg = h_disp + {3'b000, hss, 3'b000} + PCT_UNIT;
  wire logic [10:0] hs_end = hs_beg + {4'h0, hsw, 3'b000} + PCT_UNIT;
  wire logic [10:0] v_disp = {1'b0, vdh} + PCT_ONE;
  wire logic [10:0] v_tot = v_disp + {5'h00, vnd} + PCT_ONE;
  wire logic [10:0] vs_beg = v_disp + {5'h00, vss} + PCT_ONE;
  wire logic [10:0] vs_end = vs_beg + {8'h00, vsw} + PCT_ONE;

  // ****************************************
  // pixel enable divider
  // ****************************************
  localparam int DIVW = (PIX_DIV > 1) ? $clog2(PIX_DIV) : 1;
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(PIX_DIV - 1);
  logic [DIVW-1:0] div_reg;
  logic px_en;

  always_ff @(posedge mclk_i) begin
    if (rst_i || div_reg >= DIV_LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  assign px_en = (div_reg >= DIV_LAST);

  // ****************************************
  // line and frame counters
  // ****************************************
  logic [10:0] hcnt_reg;
  logic [10:0] vcnt_reg;
  logic h_last;
  logic v_last;

  // compare with >= so a shrunk period never runs past wrap
  assign h_last = (hcnt_reg >= h_tot - PCT_ONE);
  assign v_last = (vcnt_reg >= v_tot - PCT_ONE);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hcnt_reg <= '0;
    end else if (px_en) begin
      hcnt_reg <= h_last ? '0 : hcnt_reg + PCT_ONE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vcnt_reg <= '0;
    end else if (px_en && h_last) begin
      vcnt_reg <= v_last ? '0 : vcnt_reg + PCT_ONE;
    end
  end

  // ****************************************
  // sync windows
  // ****************************************
  logic v_in_nd;
  logic hs_act;
  logic vs_act;
  logic line_act;
  logic frame_act;
  logic line_evt;
  logic frame_evt;

  assign v_in_nd = (vcnt_reg >= v_disp);
  assign hs_act = (hcnt_reg >= hs_beg) && (hcnt_reg < hs_end);
  assign vs_act = (vcnt_reg >= vs_beg) && (vcnt_reg < vs_end);
  // passive pulses ignore start/width fields
  assign line_act = tft ? hs_act :
                    (hcnt_reg >= h_disp) && (hcnt_reg < h_disp + PCT_PLINE_W);
  assign frame_act = tft ? vs_act : (vcnt_reg == v_disp);
  assign line_evt = px_en && (hcnt_reg == h_disp);
  assign frame_evt = px_en && (hcnt_reg == '0) && (vcnt_reg == v_disp);

  // ****************************************
  // alternating toggle
  // ****************************************
  logic [5:0] tgl_cnt_reg;
  logic tgl_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tgl_cnt_reg <= '0;
      tgl_reg <= 1'b0;
    end else if (!tft) begin
      if (tgl_rate == '0) begin
        tgl_cnt_reg <= '0;
        if (frame_evt) begin
          tgl_reg <= ~tgl_reg;
        end
      end else if (line_evt) begin
        if (tgl_cnt_reg + PCT_TGL_ONE >= tgl_rate) begin
          tgl_cnt_reg <= '0;
          tgl_reg <= ~tgl_reg;
        end else begin
          tgl_cnt_reg <= tgl_cnt_reg + PCT_TGL_ONE;
        end
      end
    end
  end

  // ****************************************
  // output stage
  // ****************************************
  pct_sync_s sync_reg;
  logic disp_en_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg.line <= line_act ^ hpol_pnl ^ tft;
      sync_reg.frame <= frame_act ^ vpol_pnl ^ tft;
      sync_reg.hsync <= ~(hs_act ^ hpol_crt);
      sync_reg.vsync <= ~(vs_act ^ vpol_crt);
      sync_reg.toggle <= tgl_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      disp_en_reg <= 1'b0;
    end else begin
      disp_en_reg <= (hcnt_reg < h_disp) && !v_in_nd;
    end
  end

  assign sync_o = sync_reg;
  assign disp_en_o = disp_en_reg;

  // ****************************************
  // vertical resolution scheme
  // ****************************************
  logic field_odd_reg;
  logic scan_en_reg;

  always_ff @(posedge mclk_i) begin
    if (rst_i || vres != PCT_INTERLACE) begin
      field_odd_reg <= 1'b0;
    end else if (px_en && h_last && v_last) begin
      field_odd_reg <= ~field_odd_reg;
    end
  end

  // line doubling feeds the panel one line per pair
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      scan_en_reg <= 1'b1;
    end else begin
      case (pct_vres_e'(vres))
        PCT_NORMAL: scan_en_reg <= 1'b1;
        PCT_INTERLACE: scan_en_reg <= vcnt_reg[0] == field_odd_reg;
        default: scan_en_reg <= !vcnt_reg[0];
      endcase
    end
  end

  assign field_odd_o = field_odd_reg;
  assign lcd_scan_en_o = scan_en_reg;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  pct_bus_e bus_reg;
  logic ap;
  logic mapped;
  logic [3:0] rd_idx_reg;
  logic rd_map_reg;
  logic [7:0] rd_val;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic hresp_reg;

  assign ap = hsel_i && htrans_i[1] && hready_i;
  assign mapped = (haddr_i[HAW-1:6] == '0) && (haddr_i[1:0] == 2'b00) &&
                  (haddr_i[5:2] < 4'(PCT_NREG));

  always_comb begin
    case (rd_idx_reg)
      PCT_IDX_ID: rd_val = {PRODUCT_ID, PCT_REV_CODE};
      PCT_IDX_VND: rd_val = regs_reg[PCT_IDX_VND] | {v_in_nd, 7'h00};
      default: rd_val = regs_reg[rd_idx_reg];
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
    end else begin
      wr_pend_reg <= ap && hwrite_i && mapped;
      wr_idx_reg <= haddr_i[5:2];
    end
  end

  // reads take one wait state so hrdata comes from a flop
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_reg <= PCT_BUS_IDLE;
      hready_reg <= 1'b1;
      hrdata_reg <= '0;
      rd_idx_reg <= '0;
      rd_map_reg <= 1'b0;
    end else begin
      case (bus_reg)
        PCT_BUS_IDLE: begin
          if (ap && !hwrite_i) begin
            bus_reg <= PCT_BUS_RDWAIT;
            hready_reg <= 1'b0;
            rd_idx_reg <= haddr_i[5:2];
            rd_map_reg <= mapped;
          end
        end
        PCT_BUS_RDWAIT: begin
          hrdata_reg <= rd_map_reg ? {24'h00_0000, rd_val} : '0;
          hready_reg <= 1'b1;
          bus_reg <= PCT_BUS_IDLE;
        end
        default: begin
          bus_reg <= PCT_BUS_IDLE;
          hready_reg <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    hresp_reg <= 1'b0;
  end

  assign hreadyout_o = hready_reg;
  assign hrdata_o = hrdata_reg;
  assign hresp_o = hresp_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_hwrap;
    px_en && h_last |=> hcnt_reg == '0;
  endproperty
  a_hwrap: assert property (p_hwrap) else $error("line did not wrap");

  property p_vwrap;
    px_en && h_last && v_last |=> vcnt_reg == '0;
  endproperty
  a_vwrap: assert property (p_vwrap) else $error("frame did not wrap");

  property p_hlead;
    $rose(hs_act) && $stable(hs_beg) && $stable(hs_end) |->
      hcnt_reg == h_disp + {3'b000, hss, 3'b000} + PCT_UNIT;
  endproperty
  a_hlead: assert property (p_hlead) else $error("hsync lead wrong");

  property p_hpol;
    !$past(rst_i) |-> sync_reg.hsync == ($past(hs_act) ? $past(hpol_crt) : !$past(hpol_crt));
  endproperty
  a_hpol: assert property (p_hpol) else $error("hsync polarity wrong");

  property p_vpol;
    !$past(rst_i) |-> sync_reg.vsync == ($past(vs_act) ? $past(vpol_crt) : !$past(vpol_crt));
  endproperty
  a_vpol: assert property (p_vpol) else $error("vsync polarity wrong");

  property p_lpol;
    !$past(rst_i) && $past(tft) && !$past(hpol_pnl) |->
      sync_reg.line == !$past(line_act);
  endproperty
  a_lpol: assert property (p_lpol) else $error("tft line pulse polarity");

  property p_fpol;
    !$past(rst_i) && !$past(tft) && !$past(vpol_pnl) |->
      sync_reg.frame == $past(frame_act);
  endproperty
  a_fpol: assert property (p_fpol) else $error("passive frame polarity");

  property p_stat;
    rd_idx_reg == PCT_IDX_VND |-> rd_val[PCT_VND_STAT] == (vcnt_reg >= v_disp);
  endproperty
  a_stat: assert property (p_stat) else $error("status bit wrong");

  property p_tgl;
    !tft && tgl_rate == '0 && frame_evt |=> tgl_reg != $past(tgl_reg);
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle missed frame");

  property p_rd;
    bus_reg == PCT_BUS_IDLE && ap && !hwrite_i |=> !hready_reg ##1 hready_reg;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");

endmodule
`default_nettype wire

// >>> verification/pct_panel_model.sv
// Purpose: far-side receiver timing one sync line against the blank signal
// Assumes: one pixel per mclk, active level supplied by the caller
// Notes: figures hold the last complete pulse, in mclk cycles
`default_nettype none
module pct_panel_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic sig_i,
  input wire logic act_i,
  input wire logic disp_i,
  output int period_o,
  output int width_o,
  output int delay_o,
  output int drun_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic on;
  logic on_q;
  logic disp_q;
  int per_c;
  int wid_c;
  int dly_c;
  int run_c;
  assign on = (sig_i == act_i);
  // ****************************************
  // edge timing
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      on_q <= 1'b0;
      disp_q <= 1'b0;
      {per_c, wid_c, dly_c, run_c} <= '0;
      {period_o, width_o, delay_o, drun_o} <= '0;
    end else begin
      on_q <= on;
      disp_q <= disp_i;
      per_c <= per_c + 1;
      wid_c <= wid_c + 1;
      dly_c <= dly_c + 1;
      run_c <= run_c + 1;
      if (on && !on_q) begin
        period_o <= per_c;
        delay_o <= dly_c;
        per_c <= 1;
        wid_c <= 1;
      end
      if (!on && on_q) width_o <= wid_c;
      // delay counts from the last blank start, so a frame pulse sees a whole line
      if (!disp_i && disp_q) begin
        dly_c <= 1;
        drun_o <= run_c;
      end
      if (disp_i && !disp_q) run_c <= 1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/test_pct_timing_top.sv
// Purpose: self-checking bench for the panel/crt timing block
// Assumes: one pixel per mclk, single-word ahb transfers
// Notes: legal random timings from a fixed seed, polarities and panels by loop
`default_nettype none
module test_pct_timing_top import pct_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // clock, reset and wiring
  // ****************************************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic rdy, hresp, disp, tft, color, dual, fmt2, fodd, scan, rdy_s;
  logic [31:0] hrdata, rd_s;
  logic [1:0] vres;
  pct_sync_s sync;
  logic [3:0] acts = 4'h0;
  logic [3:0] sig;
  logic [31:0] seed = 32'h0001_77f3;
  int n_errors = 0;
  int num_checks = 0;
  int per[4], wid[4], dly[4], drun[4];
  int tcnt = 0;
  int tgap = 0;
  logic tg_q = 1'b0;
  logic ln_q = 1'b0;
  int fcnt = 0;
  logic fo_q = 1'b0;
  assign sig = {sync.frame, sync.vsync, sync.line, sync.hsync};
  always #25 mclk = ~mclk;
  // registered outputs are stable from the falling edge to the next rise
  always @(negedge mclk) begin
    rdy_s = rdy;
    rd_s = hrdata;
  end
  // product id value is arbitrary
  pct_timing_top #(.PRODUCT_ID(6'h15)) dut (.mclk_i(mclk), .rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(rdy), .hreadyout_o(rdy), .hrdata_o(hrdata),
    .hresp_o(hresp), .sync_o(sync), .disp_en_o(disp), .panel_tft_o(tft),
    .panel_color_o(color), .panel_dual_o(dual), .panel_fmt2_o(fmt2),
    .vres_mode_o(vres), .field_odd_o(fodd), .lcd_scan_en_o(scan));
  for (genvar g = 0; g < 4; g++) begin : g_far
    pct_panel_model far (.mclk_i(mclk), .rst_i(rst), .sig_i(sig[g]), .act_i(acts[g]),
      .disp_i(disp), .period_o(per[g]), .width_o(wid[g]), .delay_o(dly[g]),
      .drun_o(drun[g]));
  end
  // line pulses between alternating toggle flips
  always @(posedge mclk) begin
    if (sync.line === acts[1] && ln_q !== acts[1]) tcnt = tcnt + 1;
    ln_q = sync.line;
    if (sync.toggle !== tg_q) begin
      tgap = tcnt;
      tcnt = 0;
    end
    tg_q = sync.toggle;
    if (fodd !== fo_q) fcnt = fcnt + 1;
    fo_q = fodd;
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] expv(input int i, input logic [7:0] v);
    case (i)
      0: return 8'h54;
      2: return v & 8'h0f;
      3, 10, 11: return v & 8'h3f;
      4: return v & 8'h7f;
      5, 6: return v & 8'h1f;
      7: return v & 8'hcf;
      8: return v;
      9: return v & 8'h03;
      12: return v & 8'hc7;
      13: return v & 8'h60;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    int t;
    t = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {26'h000_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge mclk); t++; end while (rdy_s !== 1'b1 && t < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    do begin @(posedge mclk); t++; end while (rdy_s !== 1'b1 && t < 100);
    rd = rd_s[7:0];
    chk("bus response", {31'h0, hresp}, 32'h0000_0000);
    if (t >= 100) chk("bus ready", 32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************
  // timing scenario
  // ****************************************
  task automatic cfg(input logic t, input logic p, input logic [5:0] n);
    int hdw, hnd, hss, hsw, vdh, vnd, vss, vsw, ht, vt, w;
    logic [7:0] d;
    hss = rnd() % 3;
    hsw = rnd() % 4;
    hnd = hss + hsw + 1 + rnd() % 3;
    if (hnd < 3) hnd = 3;
    hdw = 3 + 2 * (rnd() % 3);
    vss = rnd() % 3;
    vsw = (rnd() % 2 == 1) ? 7 : rnd() % 4;
    vnd = vss + vsw + 1 + rnd() % 2;
    vdh = 2 + rnd() % 8;
    ht = (hdw + hnd + 2) * 8;
    vt = vdh + vnd + 2;
    acts = {p ^ t, p, p ^ t, p};
    bus(1'b1, PCT_IDX_PANEL, {7'h00, t}, d);
    bus(1'b1, PCT_IDX_MODE, 8'h00, d);
    bus(1'b1, PCT_IDX_TGL, {2'h0, n}, d);
    bus(1'b1, PCT_IDX_HDW, 8'(hdw), d);
    bus(1'b1, PCT_IDX_HND, 8'(hnd), d);
    bus(1'b1, PCT_IDX_HSS, 8'(hss), d);
    bus(1'b1, PCT_IDX_HSW, {p, ~p, 2'h0, 4'(hsw)}, d);
    bus(1'b1, PCT_IDX_VDL, 8'(vdh), d);
    bus(1'b1, PCT_IDX_VDH, 8'h00, d);
    bus(1'b1, PCT_IDX_VND, 8'(vnd), d);
    bus(1'b1, PCT_IDX_VSS, 8'(vss), d);
    bus(1'b1, PCT_IDX_VSW, {p, ~p, 3'h0, 3'(vsw)}, d);
    repeat (3 * ht * vt) @(posedge mclk);
    // settle just after a display-line hsync; blank lines would stretch the delay
    w = 0;
    while (disp !== 1'b1 && w < 20000) begin @(posedge mclk); w++; end
    while (disp !== 1'b0 && w < 20000) begin @(posedge mclk); w++; end
    repeat ((hss + hsw + 2) * 8 + 2) @(posedge mclk);
    chk("line period", per[0], ht);
    chk("display run", drun[0], (hdw + 1) * 8);
    chk("hsync width", wid[0], (hsw + 1) * 8);
    chk("hsync delay", dly[0], (hss + 1) * 8);
    chk("vsync period", per[2], ht * vt);
    chk("vsync width", wid[2], (vsw + 1) * ht);
    chk("vsync delay", dly[2], (hnd + 1) * 8 + (vss + 1) * ht);
    chk("line width", wid[1], t ? (hsw + 1) * 8 : 8);
    chk("frame width", wid[3], t ? (vsw + 1) * ht : ht);
    if (t) chk("line delay", dly[1], (hss + 1) * 8);
    if (t) chk("frame delay", dly[3], (hnd + 1) * 8 + (vss + 1) * ht);
    if (!t) chk("toggle gap", tgap, (n != 0) ? n : vt);
    w = 0;
    while (sync.vsync !== p && w < 20000) begin @(posedge mclk); w++; end
    bus(1'b0, PCT_IDX_VND, 8'h00, d);
    chk("status in blank", {24'h0, d}, {24'h0, 2'b10, 6'(vnd)});
    w = 0;
    while (disp !== 1'b1 && w < 20000) begin @(posedge mclk); w++; end
    bus(1'b0, PCT_IDX_VND, 8'h00, d);
    chk("status in display", {24'h0, d}, {24'h0, 2'b00, 6'(vnd)});
    chk("scan in normal", {31'h0, scan}, 32'h0000_0001);
    chk("field in normal", {31'h0, fodd}, 32'h0000_0000);
    bus(1'b1, PCT_IDX_MODE, 8'h40, d);
    w = fcnt;
    // two whole frames hold exactly two frame ends
    repeat (2 * ht * vt + 1) @(posedge mclk);
    @(negedge mclk);
    chk("interlace field flips", fcnt - w, 32'h0000_0002);
    $display("timing test tft %0d pol %0d rate %0d done", t, p, n);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    logic [7:0] d;
    logic [7:0] v;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 4'(i), 8'h00, d);
      chk("reset value", {24'h0, d & ((i == 10) ? 8'h7f : 8'hff)}, expv(i, 8'h00));
      v = 8'(rnd());
      bus(1'b1, 4'(i), v, d);
      bus(1'b0, 4'(i), 8'h00, d);
      chk("read back", {24'h0, d & ((i == 10) ? 8'h7f : 8'hff)}, expv(i, v));
    end
    $display("register test done");
    for (int k = 0; k < 16; k++) begin
      bus(1'b1, PCT_IDX_PANEL, 8'(k), d);
      bus(1'b1, PCT_IDX_MODE, {1'b0, 2'(k), 5'h00}, d);
      @(negedge mclk);
      chk("panel bits", {28'h0, fmt2, color, dual, tft}, 32'(k));
      chk("vres mode", {30'h0, vres}, 32'(k % 4));
    end
    $display("panel and mode test done");
    // first passive pass pins the per-frame toggle corner
    for (int c = 0; c < 4; c++) cfg(c[0], c[1], 6'((c == 0) ? 0 : 1 + rnd() % 5));
    results();
  end
  initial begin
    repeat (99000) @(posedge mclk);
    chk("watchdog", 32'h0000_0000, 32'h0000_0001);
    results();
  end
endmodule
`default_nettype wire
